/* File: core/buck_mode_meas_sync_control.sv */
// mode choice, load measurement, sync clock and power-up control
`timescale 1ns/1ps
`default_nettype none
module buck_mode_meas_sync_control #(
    parameter int POR_CYCLES = 16,
    parameter int OTP_CYCLES = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic analogSupplyOk,
    input wire logic extSyncClkIn,
    input wire logic enPin,
    input wire logic [1:0][buck_ctrl_pkg::CUR_W-1:0] loadCurrentMa,
    input wire buck_ctrl_pkg::settings_s otpDefaults,
    input wire logic settingsWrite,
    input wire buck_ctrl_pkg::settings_s settingsData,
    input wire logic [1:0] regEnable,
    input wire logic [1:0] enPinCtrl,
    input wire logic measSelectWrite,
    input wire logic measTargetSel,
    input wire logic measDoneClear,
    input wire logic measDoneMask,
    input wire logic syncClkClear,
    input wire logic syncClkMask,
    input wire logic freqSpreadEnable,
    input wire logic extSyncEnable,
    input wire logic [4:0] extClkNominalFreq,
    output logic [1:0] pwmMode,
    output logic [1:0] convEnable,
    output buck_ctrl_pkg::settings_s settings,
    output logic hostIfEnable,
    output logic [1:0] devState,
    output logic pllEnable,
    output logic clkSelExt,
    output logic spreadActive,
    output logic [3:0] freqTrim,
    output logic measBusy,
    output buck_ctrl_pkg::load_result_s loadResult,
    output logic measDoneFlag,
    output logic syncClkFlag,
    output logic irqActive
);
    // refuse parameter values the sequence counter cannot serve
    if (POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_porCheck
        $error("POR_CYCLES out of range");
    end
    if (OTP_CYCLES < 1 || OTP_CYCLES > 65535) begin : g_otpCheck
        $error("OTP_CYCLES out of range");
    end

    function automatic logic [8:0] toCode(input logic [13:0] ma);
        logic [13:0] q;
        q = ma / 14'(buck_ctrl_pkg::LOAD_LSB_MA);
        if (ma >= 14'(buck_ctrl_pkg::LOAD_MAX_MA)) begin
            toCode = 9'(buck_ctrl_pkg::LOAD_MAX_CODE);
        end else begin
            toCode = q[8:0];
        end
    endfunction : toCode

    // pin synchronisers
    logic [1:0] supplySync_q;
    logic [1:0] enSync_q;
    logic [1:0] clkinSync_q;
    logic clkinPrev_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supplySync_q <= 2'h0;
            enSync_q <= 2'h0;
            clkinSync_q <= 2'h0;
            clkinPrev_q <= 1'b0;
        end else begin
            supplySync_q <= {supplySync_q[0], analogSupplyOk};
            enSync_q <= {enSync_q[0], enPin};
            clkinSync_q <= {clkinSync_q[0], extSyncClkIn};
            clkinPrev_q <= clkinSync_q[1];
        end
    end
    wire supplyOk = supplySync_q[1];
    wire enLevel = enSync_q[1];
    wire clkinRise = clkinSync_q[1] & ~clkinPrev_q;

    // power-up sequence
    buck_ctrl_pkg::dev_state_e state_q, state_d;
    logic [15:0] seqCnt_q;
    wire seqDone = (state_q == buck_ctrl_pkg::ST_POR)
        ? (seqCnt_q == 16'(POR_CYCLES - 1))
        : (seqCnt_q == 16'(OTP_CYCLES - 1));
    wire runState = state_q[1];
    logic [1:0] convEnable_d;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            convEnable_d[i] = runState & regEnable[i]
                & (~enPinCtrl[i] | enLevel);
        end
    end
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            buck_ctrl_pkg::ST_POR: begin
                if (seqDone) begin
                    state_d = buck_ctrl_pkg::ST_OTP;
                end
            end
            buck_ctrl_pkg::ST_OTP: begin
                if (seqDone) begin
                    state_d = buck_ctrl_pkg::ST_STANDBY;
                end
            end
            buck_ctrl_pkg::ST_STANDBY: begin
                if (|convEnable_d) begin
                    state_d = buck_ctrl_pkg::ST_ACTIVE;
                end
            end
            buck_ctrl_pkg::ST_ACTIVE: begin
                if (~|convEnable_d) begin
                    state_d = buck_ctrl_pkg::ST_STANDBY;
                end
            end
        endcase
        if (~supplyOk) begin
            state_d = buck_ctrl_pkg::ST_POR;
        end
    end
    wire toStandby = (state_q == buck_ctrl_pkg::ST_OTP)
        & (state_d == buck_ctrl_pkg::ST_STANDBY);
    wire toActive = (state_q == buck_ctrl_pkg::ST_STANDBY)
        & (state_d == buck_ctrl_pkg::ST_ACTIVE);
    wire otpLoad = toStandby;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= buck_ctrl_pkg::ST_POR;
            seqCnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            seqCnt_q <= (state_d != state_q || ~supplyOk)
                ? 16'h0000 : seqCnt_q + 16'h0001;
        end
    end

    // settings: OTP defaults, host overwrite once standby is reached
    buck_ctrl_pkg::settings_s settings_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settings_q <= '0;
        end else if (otpLoad) begin
            settings_q <= otpDefaults;
        end else if (settingsWrite && runState) begin
            settings_q <= settingsData;
        end
    end

    // external clock detector
    wire pllEn_d = runState & extSyncEnable;
    logic [7:0] winCnt_q;
    logic [7:0] edgeCnt_q;
    logic extValid_q;
    wire winEnd = (winCnt_q == 8'(buck_ctrl_pkg::DET_CYCLES - 1));
    wire [11:0] edgeTimes10 = 12'(edgeCnt_q) * 12'h00a;
    wire [11:0] nomBase = 12'(extClkNominalFreq)
        * 12'(buck_ctrl_pkg::DET_WINDOW_US);
    wire nomLegal = (extClkNominalFreq >= 5'(buck_ctrl_pkg::FREQ_MIN_MHZ))
        & (extClkNominalFreq <= 5'(buck_ctrl_pkg::FREQ_MAX_MHZ));
    wire inTol = nomLegal
        & (edgeTimes10 >= nomBase * 12'(buck_ctrl_pkg::TOL_LO_TENTHS))
        & (edgeTimes10 <= nomBase * 12'(buck_ctrl_pkg::TOL_HI_TENTHS));
    wire extValid_d = ~pllEn_d ? 1'b0 : (winEnd ? inTol : extValid_q);
    wire clkEvent = pllEn_d & winEnd & (inTol != extValid_q);
    wire missEvent = extSyncEnable & ~extValid_q
        & (toStandby | toActive);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            winCnt_q <= 8'h00;
            edgeCnt_q <= 8'h00;
            extValid_q <= 1'b0;
        end else begin
            winCnt_q <= (~pllEn_d | winEnd) ? 8'h00 : winCnt_q + 8'h01;
            edgeCnt_q <= (~pllEn_d | winEnd) ? 8'h00
                : edgeCnt_q + 8'(clkinRise);
            extValid_q <= extValid_d;
        end
    end

    // spread-spectrum triangle dither
    wire spread_d = runState & freqSpreadEnable & ~extSyncEnable;
    logic [2:0] divCnt_q;
    logic [3:0] trim_q;
    logic trimDown_q;
    wire divEnd = (divCnt_q == 3'(buck_ctrl_pkg::SPREAD_DIV - 1));
    wire nearTop = (trim_q == 4'(buck_ctrl_pkg::SPREAD_TOP - 1));
    wire nearBottom = (trim_q == 4'h1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_q <= 3'h0;
            trim_q <= 4'h8;
            trimDown_q <= 1'b0;
        end else if (~spread_d) begin
            divCnt_q <= 3'h0;
            trim_q <= 4'h8;
            trimDown_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_q + 3'h1;
            if (divEnd) begin
                trim_q <= trimDown_q ? trim_q - 4'h1 : trim_q + 4'h1;
                trimDown_q <= (trimDown_q & ~nearBottom)
                    | (~trimDown_q & nearTop);
            end
        end
    end

    // load-current measurement
    logic measBusy_q;
    logic measTarget_q;
    logic [10:0] measCnt_q;
    buck_ctrl_pkg::load_result_s result_q;
    wire measStart = measSelectWrite & runState;
    wire measCapture = measBusy_q
        & (measCnt_q == 11'(buck_ctrl_pkg::MEAS_CAPTURE));
    wire measEnd = measBusy_q
        & (measCnt_q == 11'(buck_ctrl_pkg::MEAS_DONE));
    wire [8:0] measCode = toCode(loadCurrentMa[measTarget_q]);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            measBusy_q <= 1'b0;
            measTarget_q <= 1'b0;
            measCnt_q <= 11'h000;
            result_q <= '0;
        end else begin
            if (measStart) begin
                measBusy_q <= 1'b1;
                measTarget_q <= measTargetSel;
                measCnt_q <= 11'h000;
            end else begin
                if (measEnd || ~runState) begin
                    measBusy_q <= 1'b0;
                end
                measCnt_q <= measBusy_q ? measCnt_q + 11'h001 : 11'h000;
            end
            if (measCapture && !measStart) begin
                result_q <= {measCode[7:0], measCode[8]};
            end
        end
    end

    // mode choice per converter
    logic [1:0] pwm_d;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pwm_d[i] = settings_q.fpwm[i]
                | (loadCurrentMa[i] >= 14'(buck_ctrl_pkg::PWM_THRESHOLD_MA))
                | (measBusy_q & (measTarget_q == 1'(i)));
        end
    end

    // event flags, set wins over clear
    logic measFlag_q;
    logic syncFlag_q;
    wire measSet = measEnd & ~measStart;
    wire syncSet = clkEvent | missEvent;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            measFlag_q <= 1'b0;
            syncFlag_q <= 1'b0;
        end else begin
            measFlag_q <= measSet | (measFlag_q & ~measDoneClear);
            syncFlag_q <= syncSet | (syncFlag_q & ~syncClkClear);
        end
    end
    wire irq_d = (measFlag_q & ~measDoneMask)
        | (syncFlag_q & ~syncClkMask);

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwmMode <= 2'h0;
            convEnable <= 2'h0;
            hostIfEnable <= 1'b0;
            devState <= 2'h0;
            pllEnable <= 1'b0;
            clkSelExt <= 1'b0;
            spreadActive <= 1'b0;
            freqTrim <= 4'h8;
            irqActive <= 1'b0;
        end else begin
            pwmMode <= pwm_d;
            convEnable <= convEnable_d;
            hostIfEnable <= runState;
            devState <= state_q;
            pllEnable <= pllEn_d;
            clkSelExt <= pllEn_d & extValid_q;
            spreadActive <= spread_d;
            freqTrim <= trim_q;
            irqActive <= irq_d;
        end
    end
    assign settings = settings_q;
    assign measBusy = measBusy_q;
    assign loadResult = result_q;
    assign measDoneFlag = measFlag_q;
    assign syncClkFlag = syncFlag_q;
endmodule : buck_mode_meas_sync_control
`default_nettype wire

/* File: core/buck_ctrl_pkg.sv */
// constants and carrier types for the buck mode, measure and sync control
// Function
// - auto mode: PWM from 600 mA, else PFM
// - forced PWM never enters PFM
// - select write picks converter, starts measurement
// - measured converter forced PWM, sequence within 50 us
// - measurement end sets flag, interrupt unless masked
// - 9-bit result split low byte, high bit
// - code step 20 mA, top code 10.22 A
// - spread only on internal RC, both converters
// - spread varies frequency around centre
// - sync disabled: no PLL, RC clock, no event
// - sync enabled: detector runs, auto switch, events
// - sync clock event masked by its mask bit
// - 5-bit nominal frequency, 1 to 24 MHz
// - clock valid only within ten percent
// - missing clock event at standby and active entry; code flags standby entry from OTP only, not from active
// - supply ok: reset, OTP read, interface, standby
// - OTP defaults, host may overwrite settings
// - after standby host changes settings, enables work
package buck_ctrl_pkg;
    localparam int CLK_MHZ = 25;
    localparam int MEAS_TIME_US = 50;
    localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
    localparam int MEAS_CAPTURE = MEAS_CYCLES - 2;
    localparam int MEAS_DONE = MEAS_CYCLES - 1;
    localparam int PWM_THRESHOLD_MA = 600;
    localparam int LOAD_LSB_MA = 20;
    localparam int LOAD_MAX_CODE = 511;
    localparam int LOAD_MAX_MA = 10220;
    localparam int HOST_WAIT_US = 1200;
    localparam int HOST_WAIT_CYCLES = HOST_WAIT_US * CLK_MHZ;
    localparam int DET_WINDOW_US = 8;
    localparam int DET_CYCLES = DET_WINDOW_US * CLK_MHZ;
    localparam int TOL_LO_TENTHS = 9;
    localparam int TOL_HI_TENTHS = 11;
    localparam int FREQ_MIN_MHZ = 1;
    localparam int FREQ_MAX_MHZ = 24;
    localparam int SPREAD_DIV = 8;
    localparam int SPREAD_TOP = 15;
    localparam int CUR_W = 14;

    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_OTP = 2'b01,
        ST_STANDBY = 2'b10,
        ST_ACTIVE = 2'b11
    } dev_state_e;

    typedef struct packed {
        logic [1:0][7:0] vout;
        logic [1:0] fpwm;
        logic [1:0][1:0] curLimit;
        logic [1:0][2:0] slew;
        logic [1:0][3:0] startDelay;
        logic [1:0][3:0] stopDelay;
    } settings_s;

    typedef struct packed {
        logic [7:0] low;
        logic high;
    } load_result_s;
endpackage : buck_ctrl_pkg

/* File: test/buck_ctrl_sva.sv */
// assertion checker for the buck control block
`timescale 1ns/1ps
`default_nettype none
module buck_ctrl_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic measSelectWrite,
    input wire logic measTargetSel,
    input wire logic measDoneMask,
    input wire logic syncClkMask,
    input wire logic freqSpreadEnable,
    input wire logic extSyncEnable,
    input wire logic [1:0] pwmMode,
    input wire logic hostIfEnable,
    input wire logic [1:0] devState,
    input wire logic pllEnable,
    input wire logic clkSelExt,
    input wire logic spreadActive,
    input wire logic [3:0] freqTrim,
    input wire logic measBusy,
    input wire logic measDoneFlag,
    input wire logic syncClkFlag,
    input wire logic irqActive
);
    localparam int DONE_AGE = buck_ctrl_pkg::MEAS_CYCLES + 1;
    logic [10:0] measAge_q;
    wire logic take = measSelectWrite && devState[1];
    wire logic ageRun = measAge_q != 11'h000 && measAge_q != 11'h7ff;
    // cycles since the last accepted measurement write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) measAge_q <= 11'h000;
        else if (take) measAge_q <= 11'h001;
        else if (ageRun) measAge_q <= measAge_q + 11'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence takeSeq; take; endsequence
    sequence endSeq;
        measAge_q == 11'(DONE_AGE) && $past(measBusy);
    endsequence
    chk_meas_start: assert property (takeSeq |=> measBusy)
        else $error("measurement did not start");
    chk_meas_pwm: assert property (
        takeSeq |-> ##2 pwmMode[$past(measTargetSel, 2)])
        else $error("measured converter not in pwm");
    chk_meas_done: assert property (
        endSeq |-> measDoneFlag && !measBusy)
        else $error("measurement not finished in time");
    chk_done_moment: assert property (
        $rose(measDoneFlag) |-> measAge_q == 11'(DONE_AGE))
        else $error("done flag at wrong moment");
    chk_irq_unmasked: assert property (
        measDoneFlag && !measDoneMask |=> irqActive)
        else $error("unmasked done flag gave no interrupt");
    chk_irq_cause: assert property (
        irqActive |-> $past(measDoneFlag && !measDoneMask
            || syncClkFlag && !syncClkMask))
        else $error("interrupt without unmasked flag");
    chk_sync_off: assert property (
        !extSyncEnable [*3]
            |-> !pllEnable && !clkSelExt && !$rose(syncClkFlag))
        else $error("sync logic active while disabled");
    chk_spread_rc: assert property (
        spreadActive |-> $past(freqSpreadEnable) && !$past(extSyncEnable))
        else $error("spread active without rc clock");
    chk_spread_moves: assert property (
        spreadActive [*8] ##1 spreadActive
            |-> freqTrim != $past(freqTrim, 8))
        else $error("spread frequency not moving");
    chk_host_if: assert property (
        $rose(hostIfEnable)
            |-> devState[1] && $past(devState) == buck_ctrl_pkg::ST_OTP)
        else $error("host interface on before standby");
endmodule : buck_ctrl_sva
bind buck_mode_meas_sync_control buck_ctrl_sva chk_u (.*);
`default_nettype wire

/* File: test/sync_clk_src.sv */
// external sync clock source model
`timescale 1ns/1ps
`default_nettype none
module sync_clk_src (
    input wire logic run,
    input wire logic [9:0] halfNs,
    output logic clkOut
);
    // stands still low outside a run
    always begin
        clkOut = 1'b0;
        wait (run);
        while (run) begin
            #(halfNs);
            clkOut = ~clkOut;
        end
    end
endmodule : sync_clk_src
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the buck control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, analogSupplyOk, extSyncClkIn, enPin, settingsWrite;
    logic measSelectWrite, measTargetSel, measDoneClear, measDoneMask;
    logic syncClkClear, syncClkMask, freqSpreadEnable, extSyncEnable;
    logic hostIfEnable, pllEnable, clkSelExt, spreadActive, measBusy;
    logic measDoneFlag, syncClkFlag, irqActive, srcRun;
    logic [1:0] regEnable, enPinCtrl, pwmMode, convEnable, devState;
    logic [1:0][buck_ctrl_pkg::CUR_W-1:0] loadCurrentMa;
    logic [4:0] extClkNominalFreq;
    logic [3:0] freqTrim, t;
    buck_ctrl_pkg::settings_s otpDefaults, settingsData, settings, s;
    buck_ctrl_pkg::load_result_s loadResult;
    int errors, comparisons;
    typedef struct packed {
        logic [1:0] fpwm;
        logic [13:0] ma0, ma1;
        logic [1:0] pwm;
    } row_s;
    row_s rows [6] = '{'{2'h3, 14'h0, 14'h0, 2'h3},
        '{2'h1, 14'h0, 14'hbb8, 2'h3}, '{2'h2, 14'h64, 14'h64, 2'h2},
        '{2'h0, 14'h257, 14'h258, 2'h2}, '{2'h0, 14'h258, 14'h0, 2'h1},
        '{2'h0, 14'h27ec, 14'h257, 2'h1}};
    buck_mode_meas_sync_control #(.POR_CYCLES(4), .OTP_CYCLES(4)) dut_u (.*);
    sync_clk_src src_u (.run(srcRun), .halfNs(10'h064), .clkOut(extSyncClkIn));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic meas(input logic g, input logic [13:0] ma,
            input logic [8:0] code, input logic m);
        int i;
        @(posedge clk);
        loadCurrentMa <= g ? {ma, 14'h0} : {14'h0, ma};
        measTargetSel <= g;
        measDoneMask <= m;
        measSelectWrite <= 1'b1;
        @(posedge clk);
        measSelectWrite <= 1'b0;
        @(negedge clk);
        check(measBusy, 1'b1);
        @(negedge clk);
        check(pwmMode[g], 1'b1);
        i = 0;
        while (measDoneFlag !== 1'b1 && i < 1300) begin
            @(negedge clk);
            i++;
        end
        check(i, buck_ctrl_pkg::MEAS_CYCLES - 1);
        check(loadResult, {code[7:0], code[8]});
        @(negedge clk);
        check(irqActive, !m);
        @(posedge clk);
        measDoneClear <= 1'b1;
        @(posedge clk);
        measDoneClear <= 1'b0;
    endtask : meas
    task automatic syncStep(input logic [4:0] f, input logic [1:0] sel);
        @(posedge clk);
        extClkNominalFreq <= f;
        syncClkClear <= 1'b0;
        cyc(700);
        @(negedge clk);
        check({clkSelExt, syncClkFlag}, sel);
        @(posedge clk);
        syncClkClear <= 1'b1;
    endtask : syncStep
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        report_and_stop;
    end
    initial begin
        {errors, comparisons} = 0;
        {rst, analogSupplyOk, enPin, settingsWrite, measSelectWrite} = 5'h10;
        {measTargetSel, measDoneClear, measDoneMask, syncClkClear} = 4'h0;
        {syncClkMask, extSyncEnable, srcRun, freqSpreadEnable} = 4'h1;
        {regEnable, enPinCtrl, loadCurrentMa} = 0;
        extClkNominalFreq = 5'h05;
        otpDefaults = 44'h5a3c96da53c;
        settingsData = 0;
        cyc(19);
        @(negedge clk);
        check({devState, freqTrim, measDoneFlag}, 7'h10);
        @(posedge clk);
        rst <= 1'b0;
        analogSupplyOk <= 1'b1;
        cyc(buck_ctrl_pkg::HOST_WAIT_CYCLES);
        @(negedge clk);
        check(devState, buck_ctrl_pkg::ST_STANDBY);
        check(hostIfEnable, 1'b1);
        check(settings, otpDefaults);
        foreach (rows[i]) begin
            @(posedge clk);
            s = otpDefaults;
            s.fpwm = rows[i].fpwm;
            settingsData <= s;
            settingsWrite <= 1'b1;
            loadCurrentMa <= {rows[i].ma1, rows[i].ma0};
            @(posedge clk);
            settingsWrite <= 1'b0;
            cyc(2);
            @(negedge clk);
            check(pwmMode, rows[i].pwm);
            check(settings.fpwm, rows[i].fpwm);
        end
        meas(1'b1, 14'h64, 9'h005, 1'b0);
        @(posedge clk);
        measSelectWrite <= 1'b1;
        @(posedge clk);
        measSelectWrite <= 1'b0;
        cyc(100);
        meas(1'b0, 14'h27eb, 9'h1fe, 1'b1);
        meas(1'b1, 14'h27ec, 9'h1ff, 1'b0);
        @(negedge clk);
        check(spreadActive, 1'b1);
        t = freqTrim;
        cyc(9);
        @(negedge clk);
        check(freqTrim != t, 1'b1);
        @(posedge clk);
        srcRun <= 1'b1;
        extSyncEnable <= 1'b1;
        syncStep(5'h05, 2'h3);
        @(negedge clk);
        check({pllEnable, spreadActive, irqActive}, 3'h5);
        @(posedge clk);
        syncClkMask <= 1'b1;
        syncStep(5'h07, 2'h1);
        @(negedge clk);
        check(irqActive, 1'b0);
        @(posedge clk);
        srcRun <= 1'b0;
        syncStep(5'h07, 2'h0);
        @(posedge clk);
        syncClkClear <= 1'b0;
        regEnable <= 2'h1;
        cyc(5);
        @(negedge clk);
        check({devState, convEnable, syncClkFlag}, 5'h1b);
        @(posedge clk);
        {syncClkClear, syncClkMask, extSyncEnable} <= 3'h0;
        enPinCtrl <= 2'h1;
        cyc(5);
        @(negedge clk);
        check({convEnable, pllEnable, clkSelExt}, 4'h0);
        @(posedge clk);
        enPin <= 1'b1;
        cyc(5);
        @(negedge clk);
        check(convEnable, 2'h1);
        @(posedge clk);
        analogSupplyOk <= 1'b0;
        cyc(5);
        @(negedge clk);
        check(devState, buck_ctrl_pkg::ST_POR);
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        @(negedge clk);
        check({devState, freqTrim, convEnable}, 8'h20);
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
